/* File: rsr_seq.sv */
// reset, stop recovery and low-power sequencer on the crystal clock
// How it works
// - external pin low long enough resets, sets flag
// - internal reset: pin low 32, hold 32
// - power-on: clocks stopped 4096, pin low
// - pin released 32, CPU started 32 later
// - power-on sets its flag, clears others
// - low voltage holds pin, then 4096 stabilization
// - watchdog overflow resets; write FFFF clears it
// - bad opcode or disabled stop resets
// - bad fetch address resets, data access not
// - cause register read clears; flags accumulate
// - pin still low 32 after release: flag
// - reset loads reset vector (monitor vector in monitor mode), selects div4
// - irq or keyboard fall wakes from stop
// - break and timebase rollover wake from stop
// - stop recovery holds clocks 4096 cycles
// - short recovery option gives 32 cycles
// - timebase runs in stop only with oscillator
// - peripherals freeze in stop, resume after wake
// - reset exit from stop resets sync serial
// - wait keeps peripherals, irq wakes, no timebase access
// - stop during async frame invalidates it
`timescale 1ns/10ps
module rsr_seq
	import rsr_pkg::*;
#(
	parameter logic [17:0] WDOG_LIMIT = 18'h3fff0 // watchdog overflow count
) (
	// clock and power-on reset
	input  wire logic                 clk,
	input  wire logic                 reset,
	// pins from outside the clock domain
	input  wire logic                 rst_pin_in,
	output logic                      rst_pin_out,
	output logic                      rst_pin_oe,
	input  wire logic                 low_volt_in,
	input  wire logic                 irq_n_in,
	input  wire logic [RSR_KBD_W-1:0] kbd_n_in,
	// cpu events on the same clock
	input  wire logic                 cpu_wr,
	input  wire logic [15:0]          cpu_addr,
	input  wire logic                 opcode_fetch,
	input  wire logic                 addr_mapped,
	input  wire logic                 bad_opcode,
	input  wire logic                 stop_exec,
	input  wire logic                 wait_exec,
	input  wire logic                 monitor_mode,
	input  wire logic                 monitor_entry,
	input  wire logic                 break_req,
	input  wire logic                 timebase_roll,
	input  wire logic                 periph_irq,
	input  wire logic                 async_busy,
	// register port
	input  wire logic [7:0]           reg_addr,
	input  wire logic [7:0]           reg_wdata,
	input  wire logic                 reg_wr,
	input  wire logic                 reg_rd,
	output logic [7:0]                reg_rdata,
	// clock gating and cpu control
	output logic                      cpu_clk_en,
	output logic                      module_clk_en,
	output logic                      cpu_reset,
	output logic                      vec_load,
	output logic [15:0]               vec_addr,
	output logic                      bus_div4_sel,
	output logic                      wait_wake,
	// peripheral control
	output logic                      async_serial_run,
	output logic                      sync_serial_run,
	output logic                      timer_run,
	output logic                      timebase_run,
	output logic                      timebase_cpu_access,
	output logic                      sync_serial_reset,
	output logic                      async_frame_invalid
);

	// ****************************************
	// helpers
	// ****************************************
	// states in which the cpu is held in reset
	function automatic logic in_reset(input rsr_state_t s);
		in_reset = (s == RSR_PINDRV) || (s == RSR_HOLD) || (s == RSR_STAB) ||
			(s == RSR_LVLOW) || (s == RSR_EXTRST);
	endfunction

	// ****************************************
	// synchronisers
	// ****************************************
	logic                 rst_s1, rst_s2;       // reset pin
	logic                 lv_s1, lv_s2;         // low voltage detect
	logic                 irq_s1, irq_s2, irq_s3; // irq, third stage for edge
	logic [RSR_KBD_W-1:0] kbd_s1, kbd_s2, kbd_s3; // keyboard pins

	// two stages before any logic; third stage only feeds edge detect
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			// pin at its idle high, supply good: no false cause after reset
			{rst_s1, rst_s2, lv_s1, lv_s2} <= 4'hc;
			{irq_s1, irq_s2, irq_s3} <= 3'h7;
			kbd_s1 <= '1;
			kbd_s2 <= '1;
			kbd_s3 <= '1;
		end else begin
			{rst_s1, rst_s2} <= {rst_pin_in, rst_s1};
			{lv_s1, lv_s2} <= {low_volt_in, lv_s1};
			{irq_s1, irq_s2, irq_s3} <= {irq_n_in, irq_s1, irq_s2};
			kbd_s1 <= kbd_n_in;
			kbd_s2 <= kbd_s1;
			kbd_s3 <= kbd_s2;
		end
	end

	// ****************************************
	// state and storage
	// ****************************************
	rsr_state_t state, next_state;   // sequencer
	logic [11:0] cnt, next_cnt;      // shared 12-bit sequence counter
	logic [3:0]  ext_cnt;            // external pin low filter
	logic [17:0] wd;                 // watchdog counter
	rsr_cause_t  cause;              // reset_cause_reg
	logic [7:0]  config_q;           // option bits
	logic        int_src, next_int;  // current reset was driven by us
	logic [15:0] wvec, next_wvec;    // vector waiting for recovery end
	logic [7:0]  set_bits;           // cause flags raised this cycle
	logic        ld_reset, ld_wake, next_wait_wake; // vector load and wait wake requests
	logic        samp_pin;           // late pin sample found it low

	// ****************************************
	// decode
	// ****************************************
	wire pin_low    = ~rst_s2;
	wire lv_hit     = lv_s2;
	wire irq_fall   = irq_s3 & ~irq_s2;
	wire kbd_fall   = |(kbd_s3 & ~kbd_s2);
	wire short_rec  = config_q[RSR_CFG_SHORT_REC];
	wire osc_run    = config_q[RSR_CFG_OSC_RUN];
	wire stop_en    = config_q[RSR_CFG_STOP_EN];
	wire ext_hit    = pin_low && (ext_cnt == RSR_EXT_LAST);
	wire wd_clear   = cpu_wr && (cpu_addr == RSR_WDOG_ADDR);
	wire wd_over    = (wd == WDOG_LIMIT);
	wire bad_opcode_flag_hit   = bad_opcode || (stop_exec && !stop_en);
	wire bad_address_flag_hit   = opcode_fetch && !addr_mapped;
	wire int_hit    = wd_over || bad_opcode_flag_hit || bad_address_flag_hit || monitor_entry;
	wire [11:0] rec_last = short_rec ? RSR_SHORT_LAST : RSR_STAB_LAST;
	wire rd_cause   = reg_rd && (reg_addr == RSR_OFS_CAUSE);
	wire wr_config  = reg_wr && (reg_addr == RSR_OFS_CONFIG);
	wire stopped    = (state == RSR_STOP) || (state == RSR_RECOV);
	wire [7:0] state_view = {in_reset(state), stopped, state == RSR_WAIT,
		state == RSR_RUN, 4'h0};
	// internal flags raised together when a reset starts from run or wait
	wire [7:0] int_bits = {2'h0, wd_over, bad_opcode_flag_hit, bad_address_flag_hit, monitor_entry, 2'h0};

	// ****************************************
	// next state
	// ****************************************
	// priority: low voltage, external pin, internal causes, then modes
	always_comb begin
		next_state = state;
		next_int = int_src;
		next_wvec = wvec;
		set_bits = 8'h00;
		ld_reset = 1'b0;
		ld_wake = 1'b0;
		next_wait_wake = 1'b0;
		samp_pin = 1'b0;
		case (state)
			RSR_RUN, RSR_WAIT: begin
				if (lv_hit) begin
					next_state = RSR_LVLOW;
				end else if (ext_hit) begin
					next_state = RSR_EXTRST;
				end else if (int_hit) begin
					next_state = RSR_PINDRV;
					set_bits = int_bits;
				end else if (state == RSR_RUN && stop_exec) begin
					next_state = RSR_STOP;
				end else if (state == RSR_RUN && wait_exec) begin
					next_state = RSR_WAIT;
				end else if (state == RSR_WAIT &&
					(periph_irq || irq_fall || kbd_fall || break_req || timebase_roll)) begin
					next_state = RSR_RUN;
					next_wait_wake = 1'b1;
				end
			end
			RSR_STOP: begin
				// no cpu activity here, so no internal cause can arise
				if (lv_hit) begin
					next_state = RSR_LVLOW;
				end else if (ext_hit) begin
					next_state = RSR_EXTRST;
				end else if (irq_fall) begin
					next_state = RSR_RECOV;
					next_wvec = RSR_VEC_IRQ;
				end else if (kbd_fall) begin
					next_state = RSR_RECOV;
					next_wvec = RSR_VEC_KBD;
				end else if (break_req) begin
					next_state = RSR_RECOV;
					next_wvec = RSR_VEC_BRK;
				end else if (timebase_roll && osc_run) begin
					next_state = RSR_RECOV;
					next_wvec = RSR_VEC_TB;
				end
			end
			RSR_RECOV: begin
				if (lv_hit) begin
					next_state = RSR_LVLOW;
				end else if (ext_hit) begin
					next_state = RSR_EXTRST;
				end else if (cnt == rec_last) begin
					next_state = RSR_RUN;
					ld_wake = 1'b1;
				end
			end
			RSR_PINDRV: begin
				if (lv_hit) begin
					next_state = RSR_LVLOW;
				end else if (cnt == RSR_PIN_LAST) begin
					next_state = RSR_HOLD;
				end
			end
			RSR_HOLD: begin
				if (lv_hit) begin
					next_state = RSR_LVLOW;
				end else if (cnt == RSR_HOLD_LAST) begin
					next_state = RSR_RUN;
					ld_reset = 1'b1;
					samp_pin = int_src && pin_low;
				end
			end
			RSR_STAB: begin
				if (lv_hit) begin
					next_state = RSR_LVLOW;
				end else if (cnt == RSR_STAB_LAST) begin
					next_state = RSR_PINDRV;
				end
			end
			RSR_LVLOW: begin
				if (!lv_hit) begin
					next_state = RSR_STAB;
				end
			end
			RSR_EXTRST: begin
				if (lv_hit) begin
					next_state = RSR_LVLOW;
				end else if (!pin_low) begin
					next_state = RSR_HOLD;
				end
			end
			default: begin
				next_state = RSR_PINDRV;
			end
		endcase
		// flags that follow the entered state
		if (next_state == RSR_LVLOW && state != RSR_LVLOW) begin
			set_bits[1] = 1'b1;
			next_int = 1'b1;
		end
		if (next_state == RSR_EXTRST && state != RSR_EXTRST) begin
			set_bits[6] = 1'b1;
			next_int = 1'b0;
		end
		if (next_state == RSR_PINDRV && state != RSR_STAB) begin
			next_int = 1'b1;
		end
		if (samp_pin) begin
			set_bits[6] = 1'b1;
		end
	end

	// counter restarts on every change of state
	assign next_cnt = (next_state != state) ? 12'h000 : cnt + 12'h001;

	// ****************************************
	// sequencer registers
	// ****************************************
	// power-on enters stabilization with the pin driven
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			state <= RSR_STAB;
			cnt <= 12'h000;
			int_src <= 1'b1;
			wvec <= RSR_VEC_RESET;
		end else begin
			state <= next_state;
			cnt <= next_cnt;
			int_src <= next_int;
			wvec <= next_wvec;
		end
	end

	// external pin filter, only while nobody inside drives the pin
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			ext_cnt <= 4'h0;
		end else if (!pin_low || in_reset(state)) begin
			ext_cnt <= 4'h0;
		end else if (ext_cnt != RSR_EXT_LAST) begin
			ext_cnt <= ext_cnt + 4'h1;
		end
	end

	// watchdog counts in run and wait; frozen and cleared elsewhere
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			wd <= 18'h00000;
		end else if (wd_clear || !(state == RSR_RUN || state == RSR_WAIT)) begin
			wd <= 18'h00000;
		end else if (!wd_over) begin
			wd <= wd + 18'h00001;
		end
	end

	// ****************************************
	// registers seen by software
	// ****************************************
	// a new flag wins over a read in the same cycle, so no cause is lost
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			cause <= RSR_CAUSE_RST;
			config_q <= RSR_CONFIG_RST;
			reg_rdata <= 8'h00;
		end else begin
			cause <= (rd_cause ? 8'h00 : (cause & 8'hfe)) | (set_bits & 8'hfe);
			if (wr_config) begin
				config_q <= reg_wdata & 8'h07;
			end
			reg_rdata <= (reg_addr == RSR_OFS_CAUSE) && reg_rd ? cause :
				(reg_addr == RSR_OFS_CONFIG) && reg_rd ? config_q :
				(reg_addr == RSR_OFS_STATE) && reg_rd ? state_view : 8'h00;
		end
	end

	// ****************************************
	// cpu side outputs
	// ****************************************
	// vector and pulses are registered; monitor mode alters the high byte
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			vec_load <= 1'b0;
			vec_addr <= RSR_VEC_RESET;
			bus_div4_sel <= 1'b0;
			wait_wake <= 1'b0;
			sync_serial_reset <= 1'b0;
			async_frame_invalid <= 1'b0;
		end else begin
			vec_load <= ld_reset || ld_wake;
			if (ld_reset) begin
				vec_addr <= monitor_mode ? RSR_VEC_MON : RSR_VEC_RESET;
			end else if (ld_wake) begin
				vec_addr <= wvec;
			end
			bus_div4_sel <= ld_reset;
			wait_wake <= next_wait_wake;
			sync_serial_reset <= stopped && in_reset(next_state);
			async_frame_invalid <= (next_state == RSR_STOP) && (state != RSR_STOP) &&
				async_busy;
		end
	end

	// pin is open drain: output low, enable while driving
	assign rst_pin_out = 1'b0;
	assign rst_pin_oe = (state == RSR_PINDRV) || (state == RSR_STAB) ||
		(state == RSR_LVLOW);
	assign cpu_reset = in_reset(state);
	assign cpu_clk_en = (state == RSR_RUN);
	assign module_clk_en = (state == RSR_RUN) || (state == RSR_WAIT);

	// ****************************************
	// peripheral run control
	// ****************************************
	// freezing keeps registers and counts; they pick up after the wake
	assign async_serial_run = module_clk_en;
	assign sync_serial_run = module_clk_en;
	assign timer_run = module_clk_en;
	assign timebase_run = module_clk_en || (state == RSR_STOP && osc_run);
	assign timebase_cpu_access = (state == RSR_RUN);

	// ****************************************
	// assertions
	// ****************************************
	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);

	a_pin_drive_len: assert property (
		state == RSR_PINDRV && cnt == 12'h01f && !lv_hit |=> state == RSR_HOLD && !rst_pin_oe)
		else $error("pin drive not 32 cycles");
	a_hold_vector: assert property (
		state == RSR_HOLD && cnt == 12'h01f && !lv_hit && !monitor_mode |=>
		vec_load && bus_div4_sel && vec_addr == 16'hfffe && cpu_clk_en)
		else $error("reset vector not loaded after hold");
	a_stab_gated: assert property (
		state == RSR_STAB |-> rst_pin_oe && !cpu_clk_en && !module_clk_en)
		else $error("clocks or pin wrong in stabilization");
	a_stab_end: assert property (
		state == RSR_STAB && cnt == 12'hfff && !lv_hit |=> state == RSR_PINDRV ##1
		state == RSR_PINDRV)
		else $error("stabilization end wrong");
	a_lv_holds_pin: assert property (
		lv_hit |=> rst_pin_oe && (cause.low_voltage_flag || $past(rd_cause)))
		else $error("low voltage not driving pin");
	a_cause_clear: assert property (
		rd_cause && set_bits == 8'h00 |=> cause == 8'h00 && reg_rdata == $past(cause))
		else $error("cause register not cleared on read");
	a_bad_stop: assert property (
		state == RSR_RUN && stop_exec && !stop_en && !lv_hit && !ext_hit |=>
		state == RSR_PINDRV && cause.bad_opcode_flag)
		else $error("disabled stop did not reset");
	a_irq_wake: assert property (
		state == RSR_STOP && irq_fall && !lv_hit && !ext_hit |=>
		state == RSR_RECOV && !cpu_clk_en ##1 wvec == 16'hfffa)
		else $error("irq did not start recovery");
	a_short_recov: assert property (
		state == RSR_RECOV && short_rec && cnt == 12'h01f && !lv_hit && !ext_hit |=>
		vec_load && state == RSR_RUN)
		else $error("short recovery length wrong");
	a_tb_stop: assert property (
		state == RSR_STOP && !osc_run |-> !timebase_run && !timer_run)
		else $error("timebase running in stop without oscillator");
	a_wdog_reset: assert property (
		state == RSR_RUN && wd_over && !lv_hit && !ext_hit |=> cause.wdog && rst_pin_oe)
		else $error("watchdog overflow did not reset");

endmodule

/* File: rsr_pkg.sv */
// constants, types and register map of the reset and stop recovery sequencer
package rsr_pkg;

	// ****************************************
	// register map (byte offsets on the plain port)
	// ****************************************
	localparam logic [7:0] RSR_OFS_CAUSE  = 8'h00; // reset_cause_reg, read clears
	localparam logic [7:0] RSR_OFS_CONFIG = 8'h01; // recovery and stop options
	localparam logic [7:0] RSR_OFS_STATE  = 8'h02; // sequencer state, read only

	// config field positions
	localparam int RSR_CFG_SHORT_REC = 0;          // short_recovery_sel
	localparam int RSR_CFG_OSC_RUN   = 1;          // osc_run_in_stop
	localparam int RSR_CFG_STOP_EN   = 2;          // stop instruction allowed

	// values after reset
	localparam logic [7:0] RSR_CAUSE_RST  = 8'h80; // only power-on flag set
	localparam logic [7:0] RSR_CONFIG_RST = 8'h00; // full recovery, osc off, stop illegal

	// ****************************************
	// vectors loaded into the program counter, and the watchdog clear address
	// ****************************************
	localparam logic [15:0] RSR_VEC_RESET = 16'hfffe;
	localparam logic [15:0] RSR_VEC_MON   = 16'hfefe;
	localparam logic [15:0] RSR_VEC_IRQ   = 16'hfffa;
	localparam logic [15:0] RSR_VEC_KBD   = 16'hffde;
	localparam logic [15:0] RSR_VEC_BRK   = 16'hfffc;
	localparam logic [15:0] RSR_VEC_TB    = 16'hffdc;
	localparam logic [15:0] RSR_WDOG_ADDR = 16'hffff; // any write clears the watchdog

	// ****************************************
	// cycle counts of the crystal clock, and the keyboard pin count
	// ****************************************
	localparam logic [11:0] RSR_PIN_LAST   = 12'h01f; // 32 cycles pin driven
	localparam logic [11:0] RSR_HOLD_LAST  = 12'h01f; // 32 cycles held after release
	localparam logic [11:0] RSR_STAB_LAST  = 12'hfff; // 4096 cycles stabilization
	localparam logic [11:0] RSR_SHORT_LAST = 12'h01f; // 32 cycle short recovery
	localparam logic [3:0]  RSR_EXT_LAST   = 4'h3;    // pin low 4 cycles = external reset
	localparam int          RSR_KBD_W      = 5;       // keyboard wake pins

	// ****************************************
	// types
	// ****************************************
	typedef struct packed {
		logic por;    // power-on
		logic pin;    // external pin
		logic wdog;   // watchdog_flag
		logic bad_opcode_flag;   // bad_opcode_flag
		logic bad_address_flag;   // bad_address_flag
		logic modrst; // monitor entry
		logic low_voltage_flag;    // low_voltage_flag
		logic rsvd;   // reads zero
	} rsr_cause_t;

	typedef enum logic [8:0] {
		RSR_RUN    = 9'h001,
		RSR_PINDRV = 9'h002,
		RSR_HOLD   = 9'h004,
		RSR_STAB   = 9'h008,
		RSR_LVLOW  = 9'h010,
		RSR_EXTRST = 9'h020,
		RSR_STOP   = 9'h040,
		RSR_RECOV  = 9'h080,
		RSR_WAIT   = 9'h100
	} rsr_state_t;

endpackage

/* File: rsr_far_side.sv */
// model of the external reset circuit and the wake-up pins around the sequencer
`timescale 1ns/10ps
module rsr_far_side
	import rsr_pkg::*;
(
	// bench controls
	input  wire logic                 clk,
	input  wire logic                 ext_hold,
	input  wire logic                 stretch,
	input  wire logic                 irq_req,
	input  wire logic                 kbd_req,
	// device side of the pins
	input  wire logic                 rst_pin_out,
	input  wire logic                 rst_pin_oe,
	output logic                      rst_pin_in,
	output logic                      irq_n_in,
	output logic [RSR_KBD_W-1:0]      kbd_n_in
);
	// ****************************************
	// pin behaviour
	// ****************************************
	logic [5:0] tail    = '0; // slow part keeps the pin low after release
	logic [3:0] irq_cnt = '0; // cycles the interrupt pin stays low
	logic [3:0] kbd_cnt = '0; // cycles the keyboard pin stays low

	// open-drain wire with a pull-up: low while anybody pulls it
	assign rst_pin_in = ~((rst_pin_oe & ~rst_pin_out) | ext_hold | (tail != 6'h00));
	// pins are pulled up, so a falling edge is a low stretch of 8 cycles
	assign irq_n_in = (irq_cnt == 4'h0);
	assign kbd_n_in = {{(RSR_KBD_W-1){1'b1}}, kbd_cnt == 4'h0};

	// a lagging reset part outlasts the sample point after release
	always @(posedge clk) begin
		if (rst_pin_oe && stretch) tail <= 6'h28;
		else if (tail != 6'h00) tail <= tail - 6'h01;
		irq_cnt <= irq_req ? 4'h8 : irq_cnt - 4'(irq_cnt != 4'h0);
		kbd_cnt <= kbd_req ? 4'h8 : kbd_cnt - 4'(kbd_cnt != 4'h0);
	end
endmodule

/* File: tb.sv */
// self-checking bench for the reset and stop recovery sequencer
`timescale 1ns/10ps
module tb;
	import rsr_pkg::*;
	// ****************************************
	// signals and tables
	// ****************************************
	typedef struct packed {logic wr; logic [7:0] a; logic [7:0] d; logic [7:0] e;} rsr_row_t;
	typedef struct packed {logic [7:0] cfg; logic [3:0] k; logic [15:0] vec;} rsr_wake_t;
	logic                 clk = 1'b0, reset = 1'b1;
	logic                 rst_pin_in, rst_pin_out, rst_pin_oe, irq_n_in;
	logic [RSR_KBD_W-1:0] kbd_n_in;
	logic [9:0]           ev = '0; // one-cycle cpu events and wake requests
	logic                 kick = 1'b1, cpu_wr = 1'b0, mapped = 1'b1, mon = 1'b0;
	logic                 low_volt = 1'b0, busy = 1'b0, hold = 1'b0, stretch = 1'b0;
	logic [7:0]           reg_addr = '0, reg_wdata = '0, reg_rdata;
	logic                 reg_wr = 1'b0, reg_rd = 1'b0, last_div4;
	logic                 cpu_clk_en, module_clk_en, cpu_reset, vec_load, bus_div4_sel;
	logic                 wait_wake, as_run, ss_run, timer_run, timebase_run, tb_acc, ss_rst, afi;
	logic [15:0]          vec_addr, last_vec;
	int                   num_errors = 0, total_checks = 0, n_ww = 0, n_ssr = 0, n_afi = 0;
	int                   i, hi, lo, n, a0, ne;
	// register rows: write or read, address, data, expected
	rsr_row_t rr [10] = '{'{0, 0, 0, 8'h80}, '{0, 0, 0, 0}, '{1, 0, 8'hff, 0}, '{0, 0, 0, 0},
		'{1, 1, 8'h07, 0}, '{0, 1, 0, 8'h07}, '{1, 2, 8'hff, 0}, '{0, 2, 0, 8'h10},
		'{0, 8'h55, 0, 0}, '{1, 1, 0, 0}};
	// internal reset rows: source code in a, expected cause in e
	rsr_row_t rs [5] = '{'{0, 10, 0, 8'h20}, '{0, 0, 0, 8'h10}, '{0, 1, 0, 8'h08},
		'{0, 4, 0, 8'h04}, '{0, 2, 0, 8'h10}};
	rsr_wake_t ws [4] = '{'{8'h04, 8, RSR_VEC_IRQ}, '{8'h05, 9, RSR_VEC_KBD},
		'{8'h06, 5, RSR_VEC_BRK}, '{8'h07, 6, RSR_VEC_TB}};

	always #50 clk = ~clk;

	rsr_seq #(.WDOG_LIMIT(18'h00040)) i_dut (.clk(clk), .reset(reset),
		.rst_pin_in(rst_pin_in), .rst_pin_out(rst_pin_out), .rst_pin_oe(rst_pin_oe),
		.low_volt_in(low_volt), .irq_n_in(irq_n_in), .kbd_n_in(kbd_n_in), .cpu_wr(cpu_wr),
		.cpu_addr(RSR_WDOG_ADDR), .opcode_fetch(ev[1]), .addr_mapped(mapped),
		.bad_opcode(ev[0]), .stop_exec(ev[2]), .wait_exec(ev[3]), .monitor_mode(mon),
		.monitor_entry(ev[4]), .break_req(ev[5]), .timebase_roll(ev[6]),
		.periph_irq(ev[7]), .async_busy(busy), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .cpu_clk_en(cpu_clk_en),
		.module_clk_en(module_clk_en), .cpu_reset(cpu_reset), .vec_load(vec_load),
		.vec_addr(vec_addr), .bus_div4_sel(bus_div4_sel), .wait_wake(wait_wake),
		.async_serial_run(as_run), .sync_serial_run(ss_run), .timer_run(timer_run),
		.timebase_run(timebase_run), .timebase_cpu_access(tb_acc),
		.sync_serial_reset(ss_rst), .async_frame_invalid(afi));
	rsr_far_side i_far (.clk(clk), .ext_hold(hold), .stretch(stretch), .irq_req(ev[8]),
		.kbd_req(ev[9]), .rst_pin_out(rst_pin_out), .rst_pin_oe(rst_pin_oe),
		.rst_pin_in(rst_pin_in), .irq_n_in(irq_n_in), .kbd_n_in(kbd_n_in));

	// watchdog service every cycle, and catchers for the one-cycle pulses
	always @(posedge clk) begin
		cpu_wr <= kick;
		if (vec_load === 1'b1) begin
			last_vec <= vec_addr;
			last_div4 <= bus_div4_sel;
		end
		if (wait_wake === 1'b1) n_ww <= n_ww + 1;
		if (ss_rst === 1'b1) n_ssr <= n_ssr + 1;
		if (afi === 1'b1) n_afi <= n_afi + 1;
	end

	// ****************************************
	// tasks
	// ****************************************
	task automatic chk(input logic [15:0] g, input logic [15:0] e);
		total_checks++;
		if (g !== e) begin
			num_errors++;
			$display("Error at %0t ns: got %h expected %h", $time, g, e);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk) begin reg_wr <= 1'b1; reg_addr <= a; reg_wdata <= d; end
		@(posedge clk) reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		@(posedge clk) begin reg_rd <= 1'b1; reg_addr <= a; end
		@(posedge clk) reg_rd <= 1'b0;
		#1 chk(16'(reg_rdata), 16'(e));
	endtask
	task automatic fire(input int k);
		@(posedge clk) ev[k] <= 1'b1;
		@(posedge clk) ev[k] <= 1'b0;
	endtask
	// cycles until the vector load, bounded so a dead sequencer cannot hang us
	task automatic vl(output int c);
		c = 0;
		while (vec_load !== 1'b1 && c < 9000) begin @(posedge clk); #1 c++; end
		@(posedge clk);
	endtask
	// cycles of pin drive, then cycles from pin release to vector load
	task automatic seq(output int h, output int l);
		h = 0;
		l = 0;
		// step off the edge first, so a drive starting at this edge is counted
		#1;
		while (rst_pin_oe !== 1'b1 && l < 9000) begin @(posedge clk); #1 l++; end
		while (rst_pin_oe === 1'b1 && h < 9000) begin @(posedge clk); #1 h++; end
		vl(l);
	endtask
	task automatic complete_run();
		$display("checks %0d errors %0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	initial begin
		#4000000;
		num_errors++;
		complete_run();
	end

	// ****************************************
	// main sequence
	// ****************************************
	initial begin
		repeat (10) @(posedge clk);
		reset <= 1'b0;
		#1 chk(16'({cpu_clk_en, module_clk_en, rst_pin_oe}), 16'h0001);
		seq(hi, lo);
		chk(16'(hi >= 4127 && hi <= 4129), 16'h0001);
		chk(16'(lo), 16'd32);
		repeat (100) @(posedge clk);
		for (i = 0; i < 10; i++) begin
			if (rr[i].wr) wr(rr[i].a, rr[i].d);
			else rd(rr[i].a, rr[i].e);
		end
		for (i = 0; i < 5; i++) begin
			@(posedge clk) mapped <= (rs[i].a != 8'd1);
			repeat (20) @(posedge clk);
			#1 chk(16'(cpu_reset), 16'h0000);
			if (rs[i].a == 8'd10) @(posedge clk) kick <= 1'b0;
			else fire(int'(rs[i].a));
			seq(hi, lo);
			@(posedge clk) begin kick <= 1'b1; mapped <= 1'b1; end
			#1 chk(16'({lo[7:0], hi[7:0]}), 16'h2020);
			chk(last_vec, RSR_VEC_RESET);
			chk(16'(last_div4), 16'h0001);
			rd(RSR_OFS_CAUSE, rs[i].e);
		end
		// lagging pin, then a bad fetch in monitor mode, no read between
		@(posedge clk) stretch <= 1'b1;
		fire(0);
		seq(hi, lo);
		@(posedge clk) stretch <= 1'b0;
		repeat (150) @(posedge clk);
		@(posedge clk) begin mapped <= 1'b0; mon <= 1'b1; end
		fire(1);
		vl(n);
		@(posedge clk) begin mapped <= 1'b1; mon <= 1'b0; end
		#1 chk(last_vec, RSR_VEC_MON);
		rd(RSR_OFS_CAUSE, 8'h58);
		// wait mode keeps peripherals and wakes on a peripheral interrupt
		a0 = n_ww;
		fire(3);
		repeat (3) @(posedge clk);
		#1 chk(16'({cpu_clk_en, module_clk_en, timer_run, ss_run, as_run, timebase_run,
			tb_acc}), 16'h003e);
		fire(7);
		repeat (4) @(posedge clk);
		#1 chk(16'(n_ww - a0), 16'd1);
		chk(16'({cpu_clk_en, tb_acc}), 16'h0003);
		for (i = 0; i < 4; i++) begin
			wr(RSR_OFS_CONFIG, ws[i].cfg);
			a0 = n_afi;
			@(posedge clk) busy <= 1'b1;
			fire(2);
			@(posedge clk) busy <= 1'b0;
			repeat (3) @(posedge clk);
			#1 chk(16'({cpu_clk_en, timer_run, ss_run, timebase_run}), 16'(ws[i].cfg[1]));
			chk(16'(n_afi - a0), 16'd1);
			if (!ws[i].cfg[1]) begin
				fire(6);
				repeat (20) @(posedge clk);
				#1 chk(16'(cpu_clk_en), 16'h0000);
			end
			ne = ws[i].cfg[0] ? 32 : 4096;
			fire(int'(ws[i].k));
			vl(n);
			#1 chk(16'(n >= ne && n <= ne + 8), 16'h0001);
			chk(last_vec, ws[i].vec);
		end
		// stop left through an external reset
		a0 = n_ssr;
		fire(2);
		repeat (5) @(posedge clk);
		@(posedge clk) hold <= 1'b1;
		repeat (10) @(posedge clk);
		hold <= 1'b0;
		vl(n);
		#1 chk(16'(n_ssr - a0), 16'd1);
		chk(last_vec, RSR_VEC_RESET);
		rd(RSR_OFS_CAUSE, 8'h40);
		@(posedge clk) low_volt <= 1'b1;
		repeat (50) @(posedge clk);
		#1 chk(16'({rst_pin_oe, cpu_reset}), 16'h0003);
		@(posedge clk) low_volt <= 1'b0;
		seq(hi, lo);
		chk(16'(hi >= 4128), 16'h0001);
		chk(16'(lo), 16'd32);
		rd(RSR_OFS_CAUSE, 8'h02);
		complete_run();
	end
endmodule
